// ### seqcyc_defines.svh
`ifndef SEQCYC_DEFINES_SVH
`define SEQCYC_DEFINES_SVH


// ----------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------
`define SEQCYC_AW          8
`define SEQCYC_DW          32
`define SEQCYC_WORD_MASK   8'hFC
`define SEQCYC_OFF_CTRL    8'h00
`define SEQCYC_OFF_FSEL    8'h04
`define SEQCYC_OFF_FEN     8'h08
`define SEQCYC_OFF_SSEL    8'h0C
`define SEQCYC_OFF_COUNT   8'h10
`define SEQCYC_OFF_RESTART 8'h14
`define SEQCYC_OFF_ACTIVE  8'h18
`define SEQCYC_OFF_SLOT    8'h1C
`define SEQCYC_OFF_GAIN    8'h20
`define SEQCYC_OFF_EXPO    8'h24
`define SEQCYC_RESP_OKAY   2'h0
`define SEQCYC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEQCYC_CTRL_SEQ    0
`define SEQCYC_CTRL_CFG    1
`define SEQCYC_CTRL_TRIG   2
`define SEQCYC_RESTART_BIT 0
`define SEQCYC_FEN_BIT     0
`define SEQCYC_FEAT_SLOT   0
`define SEQCYC_FEAT_GAIN   1
`define SEQCYC_FEAT_EXPO   2

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SEQCYC_NSETS       32
`define SEQCYC_IDXW        5
`define SEQCYC_CNTW        6
`define SEQCYC_FSELW       2
`define SEQCYC_NFEAT       3
`define SEQCYC_SLOTW       4
`define SEQCYC_GAINW       8
`define SEQCYC_EXPW        24

// ----------------------------------------------------------------
// Reset and default values
// ----------------------------------------------------------------
`define SEQCYC_DEF_SLOT    4'h0
`define SEQCYC_DEF_GAIN    8'h01
`define SEQCYC_DEF_EXPO    24'h002710
`define SEQCYC_DEF_COUNT   6'h01
`define SEQCYC_MIN_COUNT   6'h01
`define SEQCYC_MAX_COUNT   6'h20
`define SEQCYC_CNT_ONE     6'h01
`define SEQCYC_NFEAT_SEL   2'h3
`define SEQCYC_FEN_ALL     3'h7
`define SEQCYC_FEN_NONE    3'h0
`define SEQCYC_IDX_ZERO    5'h00
`define SEQCYC_IDX_ONE     5'h01

`endif

// ### seqcyc_pkg.sv
`include "seqcyc_defines.svh"

package seqcyc_pkg;

  // ----------------------------------------------------------------
  // Parameter set entry
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`SEQCYC_SLOTW-1:0] slot;
    logic [`SEQCYC_GAINW-1:0] gain;
    logic [`SEQCYC_EXPW-1:0]  expo;
  } seqcyc_entry_t;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RDATA = 3'b100
  } seqcyc_bus_t;

  // ----------------------------------------------------------------
  // Module state
  // ----------------------------------------------------------------
  typedef struct packed {
    seqcyc_entry_t [`SEQCYC_NSETS-1:0] sets;
  } seqcyc_store_t;

  typedef struct packed {
    seqcyc_bus_t               bus;
    logic                      haveAw;
    logic                      haveW;
    logic [`SEQCYC_AW-1:0]     awAddr;
    logic [`SEQCYC_DW-1:0]     wData;
    logic [3:0]                wStrb;
    logic                      awReady;
    logic                      wReady;
    logic                      arReady;
    logic                      bValid;
    logic [1:0]                bResp;
    logic                      rValid;
    logic [`SEQCYC_DW-1:0]     rData;
    logic [1:0]                rResp;
    logic                      seqOn;
    logic                      cfgOn;
    logic                      trigOn;
    logic [`SEQCYC_FSELW-1:0]  featSel;
    logic [`SEQCYC_NFEAT-1:0]  featEn;
    logic [`SEQCYC_IDXW-1:0]   setWriteSelector;
    logic [`SEQCYC_CNTW-1:0]   setCount;
    logic [`SEQCYC_IDXW-1:0]   activeSetIndex;
    logic                      sequencing;
    seqcyc_entry_t             base;
    seqcyc_entry_t             applied;
  } seqcyc_top_t;

endpackage

// ### seqcyc_set_store.sv
`timescale 1ns/100ps
`include "seqcyc_defines.svh"

module seqcyc_set_store
  import seqcyc_pkg::*;
(
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // Write side
  input  wire logic                      loadDefaults,
  input  wire logic [`SEQCYC_NFEAT-1:0]  fieldWrite,
  input  wire logic [`SEQCYC_IDXW-1:0]   writeIdx,
  input  wire seqcyc_entry_t             writeData,
  // Read side
  input  wire logic [`SEQCYC_IDXW-1:0]   cfgIdx,
  input  wire logic [`SEQCYC_IDXW-1:0]   activeIdx,
  output seqcyc_entry_t                  cfgEntry,
  output seqcyc_entry_t                  activeEntry
);

  localparam seqcyc_entry_t DEFAULT_ENTRY = '{slot: `SEQCYC_DEF_SLOT,
                                              gain: `SEQCYC_DEF_GAIN,
                                              expo: `SEQCYC_DEF_EXPO};

  seqcyc_store_t                         state;
  seqcyc_store_t                         next_state;
  wire seqcyc_entry_t [`SEQCYC_NSETS-1:0] entryNext;

  // ----------------------------------------------------------------
  // Per-entry update
  // ----------------------------------------------------------------
  // Loading defaults overrides a field write in the same cycle.
  genvar i;
  generate
    for (i = 0; i < `SEQCYC_NSETS; i++) begin : g_entry
      wire hit = (writeIdx == `SEQCYC_IDXW'(i));
      assign entryNext[i].slot = loadDefaults ? DEFAULT_ENTRY.slot :
                                 (hit && fieldWrite[`SEQCYC_FEAT_SLOT]) ? writeData.slot :
                                 state.sets[i].slot;
      assign entryNext[i].gain = loadDefaults ? DEFAULT_ENTRY.gain :
                                 (hit && fieldWrite[`SEQCYC_FEAT_GAIN]) ? writeData.gain :
                                 state.sets[i].gain;
      assign entryNext[i].expo = loadDefaults ? DEFAULT_ENTRY.expo :
                                 (hit && fieldWrite[`SEQCYC_FEAT_EXPO]) ? writeData.expo :
                                 state.sets[i].expo;
    end
  endgenerate

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_state.sets = entryNext;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state.sets <= {`SEQCYC_NSETS{DEFAULT_ENTRY}};
    end else begin
      state <= next_state;
    end
  end

  assign cfgEntry    = state.sets[cfgIdx];
  assign activeEntry = state.sets[activeIdx];

endmodule

// ### seqcyc_cycler.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "seqcyc_defines.svh"

module seqcyc_cycler
  import seqcyc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // AXI4-Lite write address
  input  wire logic [`SEQCYC_AW-1:0]    s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [`SEQCYC_DW-1:0]    s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [`SEQCYC_AW-1:0]    s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  // AXI4-Lite read data
  output logic [`SEQCYC_DW-1:0]         s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Acquisition trigger
  input  wire logic                     trigger,
  // Sequencer outputs
  output logic [`SEQCYC_IDXW-1:0]       activeSetIndex,
  output logic                          sequencing,
  output logic [`SEQCYC_SLOTW-1:0]      appliedSlot,
  output logic [`SEQCYC_GAINW-1:0]      appliedGain,
  output logic [`SEQCYC_EXPW-1:0]       appliedExposure
);

  localparam seqcyc_entry_t DEFAULT_ENTRY = '{slot: `SEQCYC_DEF_SLOT,
                                              gain: `SEQCYC_DEF_GAIN,
                                              expo: `SEQCYC_DEF_EXPO};

  localparam seqcyc_top_t RESET_STATE = '{
    bus:              BUS_IDLE,
    haveAw:           1'b0,
    haveW:            1'b0,
    awAddr:           '0,
    wData:            '0,
    wStrb:            '0,
    awReady:          1'b0,
    wReady:           1'b0,
    arReady:          1'b0,
    bValid:           1'b0,
    bResp:            `SEQCYC_RESP_OKAY,
    rValid:           1'b0,
    rData:            '0,
    rResp:            `SEQCYC_RESP_OKAY,
    seqOn:            1'b0,
    cfgOn:            1'b0,
    trigOn:           1'b0,
    featSel:          '0,
    featEn:           `SEQCYC_FEN_NONE,
    setWriteSelector: `SEQCYC_IDX_ZERO,
    setCount:         `SEQCYC_DEF_COUNT,
    activeSetIndex:   `SEQCYC_IDX_ZERO,
    sequencing:       1'b0,
    base:             DEFAULT_ENTRY,
    applied:          DEFAULT_ENTRY
  };

  seqcyc_top_t               state;
  seqcyc_top_t               next_state;
  seqcyc_entry_t             cfgEntry;
  seqcyc_entry_t             activeEntry;
  seqcyc_entry_t             storeData;
  logic                      loadDefaults;
  logic [`SEQCYC_NFEAT-1:0]  fieldWrite;
  logic                      doWrite;
  logic                      doRead;
  logic                      restart;
  logic                      wrHit;
  logic                      rdHit;
  logic [`SEQCYC_DW-1:0]     wrOld;
  logic [`SEQCYC_DW-1:0]     wrMask;
  logic [`SEQCYC_DW-1:0]     wrVal;
  logic [`SEQCYC_DW-1:0]     rdVal;
  logic [`SEQCYC_CNTW-1:0]   nextCountUp;

  // ----------------------------------------------------------------
  // Parameter set storage
  // ----------------------------------------------------------------
  seqcyc_set_store u_store (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .loadDefaults (loadDefaults),
    .fieldWrite   (fieldWrite),
    .writeIdx     (state.setWriteSelector),
    .writeData    (storeData),
    .cfgIdx       (state.setWriteSelector),
    .activeIdx    (state.activeSetIndex),
    .cfgEntry     (cfgEntry),
    .activeEntry  (activeEntry)
  );

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  // Returns the mapped flag on top of the word. A feature value reads
  // from the selected set while it takes part in configuration, and
  // from the common value otherwise.
  function automatic logic [`SEQCYC_DW:0] regRead(input logic [`SEQCYC_AW-1:0] addr,
                                                  input seqcyc_top_t s,
                                                  input seqcyc_entry_t e);
    logic [`SEQCYC_DW-1:0] v;
    logic                  hit;
    v   = '0;
    hit = 1'b1;
    unique case (addr & `SEQCYC_WORD_MASK)
      `SEQCYC_OFF_CTRL: begin
        v[`SEQCYC_CTRL_SEQ]  = s.seqOn;
        v[`SEQCYC_CTRL_CFG]  = s.cfgOn;
        v[`SEQCYC_CTRL_TRIG] = s.trigOn;
      end
      `SEQCYC_OFF_FSEL: v[`SEQCYC_FSELW-1:0] = s.featSel;
      `SEQCYC_OFF_FEN: begin
        if (s.featSel != `SEQCYC_NFEAT_SEL) begin
          v[`SEQCYC_FEN_BIT] = s.featEn[s.featSel];
        end
      end
      `SEQCYC_OFF_SSEL:    v[`SEQCYC_IDXW-1:0] = s.setWriteSelector;
      `SEQCYC_OFF_COUNT:   v[`SEQCYC_CNTW-1:0] = s.setCount;
      `SEQCYC_OFF_RESTART: v = '0;
      `SEQCYC_OFF_ACTIVE:  v[`SEQCYC_IDXW-1:0] = s.activeSetIndex;
      `SEQCYC_OFF_SLOT: begin
        v[`SEQCYC_SLOTW-1:0] = (s.cfgOn && s.featEn[`SEQCYC_FEAT_SLOT]) ? e.slot : s.base.slot;
      end
      `SEQCYC_OFF_GAIN: begin
        v[`SEQCYC_GAINW-1:0] = (s.cfgOn && s.featEn[`SEQCYC_FEAT_GAIN]) ? e.gain : s.base.gain;
      end
      `SEQCYC_OFF_EXPO: begin
        v[`SEQCYC_EXPW-1:0] = (s.cfgOn && s.featEn[`SEQCYC_FEAT_EXPO]) ? e.expo : s.base.expo;
      end
      default: hit = 1'b0;
    endcase
    return {hit, v};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state   = state;
    loadDefaults = 1'b0;
    fieldWrite   = `SEQCYC_FEN_NONE;
    restart      = 1'b0;

    {wrHit, wrOld} = regRead(state.awAddr, state, cfgEntry);
    {rdHit, rdVal} = regRead(s_axi_araddr, state, cfgEntry);
    wrMask = {{8{state.wStrb[3]}}, {8{state.wStrb[2]}}, {8{state.wStrb[1]}}, {8{state.wStrb[0]}}};
    wrVal  = (wrOld & ~wrMask) | (state.wData & wrMask);
    storeData = '{slot: wrVal[`SEQCYC_SLOTW-1:0],
                  gain: wrVal[`SEQCYC_GAINW-1:0],
                  expo: wrVal[`SEQCYC_EXPW-1:0]};

    // Address and data are captured independently, in either order.
    if (s_axi_awvalid && state.awReady) begin
      next_state.haveAw = 1'b1;
      next_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.wReady) begin
      next_state.haveW = 1'b1;
      next_state.wData = s_axi_wdata;
      next_state.wStrb = s_axi_wstrb;
    end

    doWrite = (state.bus == BUS_IDLE) && state.haveAw && state.haveW;
    doRead  = (state.bus == BUS_IDLE) && !doWrite && s_axi_arvalid && state.arReady;

    unique case (state.bus)
      BUS_IDLE: begin
        if (doWrite) begin
          next_state.haveAw = 1'b0;
          next_state.haveW  = 1'b0;
          next_state.bValid = 1'b1;
          next_state.bResp  = wrHit ? `SEQCYC_RESP_OKAY : `SEQCYC_RESP_SLVERR;
          next_state.bus    = BUS_WRESP;
        end else if (doRead) begin
          next_state.rValid = 1'b1;
          next_state.rData  = rdHit ? rdVal : '0;
          next_state.rResp  = rdHit ? `SEQCYC_RESP_OKAY : `SEQCYC_RESP_SLVERR;
          next_state.bus    = BUS_RDATA;
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) begin
          next_state.bValid = 1'b0;
          next_state.bus    = BUS_IDLE;
        end
      end
      BUS_RDATA: begin
        if (s_axi_rready) begin
          next_state.rValid = 1'b0;
          next_state.bus    = BUS_IDLE;
        end
      end
    endcase

    // Register write effects.
    if (doWrite && wrHit) begin
      unique case (state.awAddr & `SEQCYC_WORD_MASK)
        `SEQCYC_OFF_CTRL: begin
          next_state.seqOn  = wrVal[`SEQCYC_CTRL_SEQ];
          next_state.cfgOn  = wrVal[`SEQCYC_CTRL_CFG];
          next_state.trigOn = wrVal[`SEQCYC_CTRL_TRIG];
          if (wrVal[`SEQCYC_CTRL_CFG] && !state.cfgOn) begin
            next_state.featEn = `SEQCYC_FEN_ALL;
            loadDefaults      = 1'b1;
          end
        end
        `SEQCYC_OFF_FSEL: next_state.featSel = wrVal[`SEQCYC_FSELW-1:0];
        `SEQCYC_OFF_FEN: begin
          if (state.featSel != `SEQCYC_NFEAT_SEL) begin
            next_state.featEn[state.featSel] = wrVal[`SEQCYC_FEN_BIT];
          end
        end
        `SEQCYC_OFF_SSEL: next_state.setWriteSelector = wrVal[`SEQCYC_IDXW-1:0];
        `SEQCYC_OFF_COUNT: begin
          if (wrVal[`SEQCYC_DW-1:`SEQCYC_CNTW] == '0 &&
              wrVal[`SEQCYC_CNTW-1:0] >= `SEQCYC_MIN_COUNT &&
              wrVal[`SEQCYC_CNTW-1:0] <= `SEQCYC_MAX_COUNT) begin
            next_state.setCount = wrVal[`SEQCYC_CNTW-1:0];
          end
        end
        `SEQCYC_OFF_RESTART: restart = wrVal[`SEQCYC_RESTART_BIT];
        `SEQCYC_OFF_SLOT: begin
          if (state.cfgOn && state.featEn[`SEQCYC_FEAT_SLOT]) begin
            fieldWrite[`SEQCYC_FEAT_SLOT] = 1'b1;
          end else begin
            next_state.base.slot = storeData.slot;
          end
        end
        `SEQCYC_OFF_GAIN: begin
          if (state.cfgOn && state.featEn[`SEQCYC_FEAT_GAIN]) begin
            fieldWrite[`SEQCYC_FEAT_GAIN] = 1'b1;
          end else begin
            next_state.base.gain = storeData.gain;
          end
        end
        `SEQCYC_OFF_EXPO: begin
          if (state.cfgOn && state.featEn[`SEQCYC_FEAT_EXPO]) begin
            fieldWrite[`SEQCYC_FEAT_EXPO] = 1'b1;
          end else begin
            next_state.base.expo = storeData.expo;
          end
        end
        default: ;
      endcase
    end

    // Set cycling. Triggers are ignored while sets are being configured.
    nextCountUp = `SEQCYC_CNTW'({1'b0, state.activeSetIndex}) + `SEQCYC_CNT_ONE;
    if (restart) begin
      next_state.activeSetIndex = `SEQCYC_IDX_ZERO;
    end else if (state.sequencing && trigger) begin
      if (nextCountUp >= state.setCount) begin
        next_state.activeSetIndex = `SEQCYC_IDX_ZERO;
      end else begin
        next_state.activeSetIndex = state.activeSetIndex + `SEQCYC_IDX_ONE;
      end
    end

    next_state.sequencing = next_state.seqOn && next_state.trigOn && !next_state.cfgOn;

    // Participating features follow the active set while sequencing.
    next_state.applied.slot = (state.sequencing && state.featEn[`SEQCYC_FEAT_SLOT]) ?
                              activeEntry.slot : state.base.slot;
    next_state.applied.gain = (state.sequencing && state.featEn[`SEQCYC_FEAT_GAIN]) ?
                              activeEntry.gain : state.base.gain;
    next_state.applied.expo = (state.sequencing && state.featEn[`SEQCYC_FEAT_EXPO]) ?
                              activeEntry.expo : state.base.expo;

    // Ready flags are registered so that they reflect the next state.
    next_state.awReady = (next_state.bus == BUS_IDLE) && !next_state.haveAw;
    next_state.wReady  = (next_state.bus == BUS_IDLE) && !next_state.haveW;
    next_state.arReady = (next_state.bus == BUS_IDLE) && !next_state.haveAw && !next_state.haveW;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready   = state.awReady;
  assign s_axi_wready    = state.wReady;
  assign s_axi_bresp     = state.bResp;
  assign s_axi_bvalid    = state.bValid;
  assign s_axi_arready   = state.arReady;
  assign s_axi_rdata     = state.rData;
  assign s_axi_rresp     = state.rResp;
  assign s_axi_rvalid    = state.rValid;
  assign activeSetIndex  = state.activeSetIndex;
  assign sequencing      = state.sequencing;
  assign appliedSlot     = state.applied.slot;
  assign appliedGain     = state.applied.gain;
  assign appliedExposure = state.applied.expo;

endmodule

// ### seqcyc_cycler_props.sv
`timescale 1ns/100ps
`include "seqcyc_defines.svh"
module seqcyc_cycler_props (
  // Clock and reset
  input logic        clock,
  input logic        sys_rst,
  // Bus
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  // Sequencer
  input logic        trigger,
  input logic [4:0]  activeSetIndex,
  input logic        sequencing
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire step = sequencing && trigger;
  wire both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rst0 = both && s_axi_awaddr == `SEQCYC_OFF_RESTART && s_axi_wdata[`SEQCYC_RESTART_BIT];
  property p_advance;
    step |=> activeSetIndex == $past(activeSetIndex) + 5'h01 || activeSetIndex == 5'h00;
  endproperty
  property p_hold;
    !step |=> $stable(activeSetIndex) || $rose(s_axi_bvalid);
  endproperty
  property p_restart;
    rst0 |-> ##2 activeSetIndex == 5'h00;
  endproperty
  property p_wresp;
    both |-> ##2 s_axi_bvalid;
  endproperty
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_arblock;
    s_axi_bvalid |-> !s_axi_arready;
  endproperty
  property p_awlow;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
  endproperty
  property p_rslverr;
    s_axi_rvalid && s_axi_rresp == `SEQCYC_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_advance: assert property (p_advance) else $error("index did not advance");
  a_hold: assert property (p_hold) else $error("index moved without trigger");
  a_restart: assert property (p_restart) else $error("restart missed");
  a_wresp: assert property (p_wresp) else $error("write response late");
  a_rlat: assert property (p_rlat) else $error("read data late");
  a_arblock: assert property (p_arblock) else $error("read taken during write");
  a_awlow: assert property (p_awlow) else $error("address ready too soon");
  a_rslverr: assert property (p_rslverr) else $error("error read not zero");
  c_step: cover property (step);
  c_restart: cover property (rst0);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `SEQCYC_RESP_SLVERR);
endmodule
bind seqcyc_cycler seqcyc_cycler_props chk_u (.*);

// ### seqcyc_host.sv
`timescale 1ns/100ps
module seqcyc_host (
  // Clock
  input  logic        clock,
  // Write channels
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  // Read channels
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_wstrb = 4'hF;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
  endtask
endmodule

// ### seqcyc_cycler_tb.sv
`timescale 1ns/100ps
`include "seqcyc_defines.svh"
module seqcyc_cycler_tb;
  logic        clock, sys_rst, trigger, sequencing;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, appliedGain;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, rv;
  logic [3:0]  s_axi_wstrb, appliedSlot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0]  activeSetIndex;
  logic [23:0] appliedExposure;
  int          error_cnt, checks, idx, mS[4], mG[4], mE[4];
  seqcyc_cycler dut_u (.*);
  seqcyc_host host_u (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    host_u.wr(a, d, rr);
    chk("bresp", rr, `SEQCYC_RESP_OKAY);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] exp);
    host_u.rd(a, rv, rr);
    chk(n, rv, exp);
  endtask
  // Model values of the set now in force against the applied outputs.
  task automatic look;
    chk("index", activeSetIndex, idx);
    chk("slot", appliedSlot, mS[idx]);
    chk("gain", appliedGain, mG[idx]);
    chk("expo", appliedExposure, mE[idx]);
  endtask
  task automatic trig;
    trigger <= 1'b1;
    @(posedge clock);
    trigger <= 1'b0;
    idx = (idx + 1) % 4;
    repeat (2) @(posedge clock);
    look();
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    trigger = 1'b0;
    sys_rst = 1'b1;
    lfsr = 32'h8ED2B375;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rc("active", `SEQCYC_OFF_ACTIVE, 0);
    w(`SEQCYC_OFF_CTRL, 0);
    for (int f = 0; f < 3; f++) begin
      w(`SEQCYC_OFF_FSEL, f);
      w(`SEQCYC_OFF_FEN, 1);
    end
    rc("fen", `SEQCYC_OFF_FEN, 1);
    w(`SEQCYC_OFF_CTRL, 6);
    w(`SEQCYC_OFF_SSEL, 9);
    rc("defslot", `SEQCYC_OFF_SLOT, `SEQCYC_DEF_SLOT);
    rc("defgain", `SEQCYC_OFF_GAIN, `SEQCYC_DEF_GAIN);
    rc("defexpo", `SEQCYC_OFF_EXPO, `SEQCYC_DEF_EXPO);
    for (int s = 0; s < 4; s++) begin
      lfsr = nxt(lfsr);
      mS[s] = lfsr[3:0];
      mG[s] = lfsr[11:4];
      mE[s] = lfsr[31:8];
      w(`SEQCYC_OFF_SSEL, s);
      w(`SEQCYC_OFF_SLOT, mS[s]);
      w(`SEQCYC_OFF_GAIN, mG[s]);
      w(`SEQCYC_OFF_EXPO, mE[s]);
    end
    rc("setgain", `SEQCYC_OFF_GAIN, mG[3]);
    w(`SEQCYC_OFF_COUNT, 32);
    rc("count", `SEQCYC_OFF_COUNT, 32);
    w(`SEQCYC_OFF_COUNT, 33);
    w(`SEQCYC_OFF_COUNT, 0);
    rc("count", `SEQCYC_OFF_COUNT, 32);
    w(`SEQCYC_OFF_COUNT, 4);
    rc("count", `SEQCYC_OFF_COUNT, 4);
    w(`SEQCYC_OFF_CTRL, 4);
    trigger <= 1'b1;
    @(posedge clock);
    trigger <= 1'b0;
    repeat (2) @(posedge clock);
    chk("idle", activeSetIndex, 0);
    chk("seqoff", sequencing, 0);
    w(`SEQCYC_OFF_CTRL, 5);
    chk("seqon", sequencing, 1);
    host_u.rd(8'h28, rv, rr);
    chk("rresp", rr, `SEQCYC_RESP_SLVERR);
    $display("test configure done");
    repeat (6) trig();
    $display("test cycling done");
    w(`SEQCYC_OFF_RESTART, 1);
    idx = 0;
    @(posedge clock);
    look();
    trig();
    $display("test restart done");
    final_report();
  end
endmodule
